// ### hw/plb_logic_block.sv
// Purpose: logic block with control terms, fixed and shared term arrays, 16 cells
// Assumes: all inputs synchronous to clk; config written before use
// Notes: global clocks are sampled levels, their edges detected per cell
`timescale 1ns/10ps
module plb_logic_block
   import plb_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [35:0] global_interconnect_array,
   output logic [31:0] feedback_to_interconnect,
   input wire logic global_sync_clock,
   input wire logic global_dual_clock,
   input wire logic global_tristate_pin_n,
   input wire logic [15:0] pin_in,
   output logic [15:0] pin_out,
   output logic [15:0] pin_oe,
   input wire logic [9:0] reg_addr,
   input wire logic [35:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [35:0] reg_rdata
);

   // term evaluation over true and complement literal masks
   function automatic logic term_eval(
      input logic [35:0] tmask,
      input logic [35:0] cmask,
      input logic [35:0] in_vec,
      input logic as_sum
   );
      logic [35:0] hits;
      logic [35:0] used;
      hits = (tmask & in_vec) | (cmask & ~in_vec);
      used = tmask | cmask;
      // an empty term is off, so unprogrammed terms never fire
      if (as_sum) begin
         term_eval = |hits;
      end else begin
         term_eval = (used != 36'h0_0000_0000) && (hits == used);
      end
   endfunction

   // configuration store
   logic [35:0] pal_t_reg [PLB_PAL_TERMS];
   logic [35:0] pal_t_next [PLB_PAL_TERMS];
   logic [35:0] pal_c_reg [PLB_PAL_TERMS];
   logic [35:0] pal_c_next [PLB_PAL_TERMS];
   logic [35:0] pla_t_reg [PLB_PLA_TERMS];
   logic [35:0] pla_t_next [PLB_PLA_TERMS];
   logic [35:0] pla_c_reg [PLB_PLA_TERMS];
   logic [35:0] pla_c_next [PLB_PLA_TERMS];
   logic [35:0] ct_t_reg [PLB_CTRL_TERMS];
   logic [35:0] ct_t_next [PLB_CTRL_TERMS];
   logic [35:0] ct_c_reg [PLB_CTRL_TERMS];
   logic [35:0] ct_c_next [PLB_CTRL_TERMS];
   logic [31:0] or_mask_reg [PLB_CELLS];
   logic [31:0] or_mask_next [PLB_CELLS];
   logic [35:0] cell_cfg_reg [PLB_CELLS];
   logic [35:0] cell_cfg_next [PLB_CELLS];
   logic [35:0] global_cfg_reg;
   logic [35:0] global_cfg_next;

   // register port and pin side
   logic [35:0] rdata_reg;
   logic [35:0] rdata_next;
   logic [15:0] pin_out_reg;
   logic [15:0] pin_out_next;
   logic [15:0] pin_oe_reg;
   logic [15:0] pin_oe_next;
   logic [31:0] fb_reg;
   logic [31:0] fb_next;

   logic [9:0] offset;
   logic in_pal;
   logic in_pla;
   logic in_ct;
   logic in_or;
   logic in_cell;

   logic [PLB_PLA_TERMS-1:0] pla_val;
   logic [PLB_CTRL_TERMS-1:0] ct_val;
   logic [PLB_CELLS-1:0] cell_sum;
   logic [PLB_CELLS-1:0] cell_state;
   logic [PLB_CELLS-1:0] cell_value;
   logic [PLB_CELLS-1:0] cell_oe;
   logic dual_clock_level;
   logic gts_active;

   // control terms, each its own sum or product choice
   genvar gc;
   generate
      for (gc = 0; gc < PLB_CTRL_TERMS; gc++) begin : g_ct
         assign ct_val[gc] = term_eval(ct_t_reg[gc], ct_c_reg[gc], global_interconnect_array,
                                       global_cfg_reg[PLB_CTSUM_LSB + gc]);
      end
   endgenerate

   // shared pool, evaluated once and fanned out to every cell
   genvar gp;
   generate
      for (gp = 0; gp < PLB_PLA_TERMS; gp++) begin : g_pla
         assign pla_val[gp] = term_eval(pla_t_reg[gp], pla_c_reg[gp], global_interconnect_array,
                                        1'b0);
      end
   endgenerate

   assign gts_active = global_cfg_reg[PLB_GTS_EN_BIT] & ~global_tristate_pin_n;

   // internal source for the dual clock is a cell equation
   assign dual_clock_level = global_cfg_reg[PLB_DUAL_INT_BIT]
      ? cell_sum[global_cfg_reg[PLB_DUAL_CELL_LSB +: 4]]
      : global_dual_clock;

   genvar gm;
   generate
      for (gm = 0; gm < PLB_CELLS; gm++) begin : g_cell
         logic [PLB_PAL_PER_CELL-1:0] pal_val;
         logic clk_level;
         logic [1:0] csel;
         logic [2:0] oesel;
         logic pr_en;
         logic oe_level;

         for (genvar gt = 0; gt < PLB_PAL_PER_CELL; gt++) begin : g_pal
            assign pal_val[gt] = term_eval(pal_t_reg[gm * PLB_PAL_PER_CELL + gt],
                                           pal_c_reg[gm * PLB_PAL_PER_CELL + gt],
                                           global_interconnect_array, 1'b0);
         end

         // fast path fixed OR plus any pool terms routed here
         assign cell_sum[gm] = (|pal_val) | (|(pla_val & or_mask_reg[gm]));

         assign csel = cell_cfg_reg[gm][PLB_CSEL_LSB +: 2];
         assign oesel = cell_cfg_reg[gm][PLB_OESEL_LSB +: 3];
         assign pr_en = cell_cfg_reg[gm][PLB_PREN_BIT];

         // a source switch can show one spurious edge; change sources while clocks idle
         always_comb begin
            unique case (plb_clk_sel_t'(csel))
               PLB_CLK_SYNC: clk_level = global_sync_clock;
               PLB_CLK_DUAL: clk_level = dual_clock_level;
               PLB_CLK_CT_A: clk_level = ct_val[2];
               PLB_CLK_CT_B: clk_level = ct_val[3];
            endcase
         end

         // local variable keeps each process the only writer of what it assigns
         always_comb begin
            case (oesel)
               PLB_OE_ON: oe_level = 1'b1;
               PLB_OE_CT2: oe_level = ct_val[2];
               PLB_OE_CT3: oe_level = ct_val[3];
               PLB_OE_CT4: oe_level = ct_val[4];
               PLB_OE_CT5: oe_level = ct_val[5];
               default: oe_level = 1'b0;
            endcase
         end

         assign cell_oe[gm] = oe_level;

         plb_macrocell u_cell (
            .clk(clk),
            .reset_n(reset_n),
            .logic_in(cell_sum[gm]),
            .clk_level(clk_level),
            // edge polarity only applies to the global clocks
            .clk_falling(cell_cfg_reg[gm][PLB_POL_BIT] & ~csel[1]),
            .mode(cell_cfg_reg[gm][PLB_MODE_LSB +: 2]),
            .preset(pr_en & ct_val[0]),
            .clear(pr_en & ct_val[1]),
            .state(cell_state[gm]),
            .value(cell_value[gm])
         );
      end
   endgenerate

   // address decode
   always_comb begin
      in_pal = (reg_addr >= PLB_PAL_BASE) && (reg_addr < PLB_PAL_END);
      in_pla = (reg_addr >= PLB_PLA_BASE) && (reg_addr < PLB_PLA_END);
      in_ct = (reg_addr >= PLB_CT_BASE) && (reg_addr < PLB_CT_END);
      in_or = (reg_addr >= PLB_OR_BASE) && (reg_addr < PLB_OR_END);
      in_cell = (reg_addr >= PLB_CELL_BASE) && (reg_addr < PLB_CELL_END);
      if (in_pla) begin
         offset = reg_addr - PLB_PLA_BASE;
      end else if (in_ct) begin
         offset = reg_addr - PLB_CT_BASE;
      end else if (in_or) begin
         offset = reg_addr - PLB_OR_BASE;
      end else if (in_cell) begin
         offset = reg_addr - PLB_CELL_BASE;
      end else begin
         offset = reg_addr - PLB_PAL_BASE;
      end
   end

   // configuration writes
   always_comb begin
      pal_t_next = pal_t_reg;
      pal_c_next = pal_c_reg;
      pla_t_next = pla_t_reg;
      pla_c_next = pla_c_reg;
      ct_t_next = ct_t_reg;
      ct_c_next = ct_c_reg;
      or_mask_next = or_mask_reg;
      cell_cfg_next = cell_cfg_reg;
      global_cfg_next = global_cfg_reg;
      if (reg_write) begin
         if (in_pal && !offset[0]) begin
            pal_t_next[offset[7:1]] = reg_wdata;
         end
         if (in_pal && offset[0]) begin
            pal_c_next[offset[7:1]] = reg_wdata;
         end
         if (in_pla && !offset[0]) begin
            pla_t_next[offset[5:1]] = reg_wdata;
         end
         if (in_pla && offset[0]) begin
            pla_c_next[offset[5:1]] = reg_wdata;
         end
         if (in_ct && !offset[0]) begin
            ct_t_next[offset[3:1]] = reg_wdata;
         end
         if (in_ct && offset[0]) begin
            ct_c_next[offset[3:1]] = reg_wdata;
         end
         if (in_or) begin
            or_mask_next[offset[3:0]] = reg_wdata[31:0];
         end
         if (in_cell) begin
            cell_cfg_next[offset[3:0]] = reg_wdata;
         end
         if (reg_addr == PLB_GLOBAL_ADDR) begin
            global_cfg_next = reg_wdata;
         end
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         for (int i = 0; i < PLB_PAL_TERMS; i++) begin
            pal_t_reg[i] <= PLB_WORD_RESET;
            pal_c_reg[i] <= PLB_WORD_RESET;
         end
         for (int i = 0; i < PLB_PLA_TERMS; i++) begin
            pla_t_reg[i] <= PLB_WORD_RESET;
            pla_c_reg[i] <= PLB_WORD_RESET;
         end
         for (int i = 0; i < PLB_CTRL_TERMS; i++) begin
            ct_t_reg[i] <= PLB_WORD_RESET;
            ct_c_reg[i] <= PLB_WORD_RESET;
         end
         for (int i = 0; i < PLB_CELLS; i++) begin
            or_mask_reg[i] <= PLB_WORD_RESET[31:0];
            cell_cfg_reg[i] <= PLB_WORD_RESET;
         end
         global_cfg_reg <= PLB_WORD_RESET;
      end else begin
         pal_t_reg <= pal_t_next;
         pal_c_reg <= pal_c_next;
         pla_t_reg <= pla_t_next;
         pla_c_reg <= pla_c_next;
         ct_t_reg <= ct_t_next;
         ct_c_reg <= ct_c_next;
         or_mask_reg <= or_mask_next;
         cell_cfg_reg <= cell_cfg_next;
         global_cfg_reg <= global_cfg_next;
      end
   end

   // readback; unmapped addresses read zero
   always_comb begin
      rdata_next = PLB_WORD_RESET;
      if (reg_read) begin
         if (in_pal) begin
            rdata_next = offset[0] ? pal_c_reg[offset[7:1]] : pal_t_reg[offset[7:1]];
         end else if (in_pla) begin
            rdata_next = offset[0] ? pla_c_reg[offset[5:1]] : pla_t_reg[offset[5:1]];
         end else if (in_ct) begin
            rdata_next = offset[0] ? ct_c_reg[offset[3:1]] : ct_t_reg[offset[3:1]];
         end else if (in_or) begin
            rdata_next = {4'h0, or_mask_reg[offset[3:0]]};
         end else if (in_cell) begin
            rdata_next = cell_cfg_reg[offset[3:0]];
         end else if (reg_addr == PLB_GLOBAL_ADDR) begin
            rdata_next = global_cfg_reg;
         end else if (reg_addr == PLB_STATE_ADDR) begin
            rdata_next = {20'h0_0000, cell_state};
         end else if (reg_addr == PLB_FB_ADDR) begin
            rdata_next = {4'h0, fb_reg};
         end
      end
   end

   // pin drive and feedback, one register stage to the outside
   always_comb begin
      pin_out_next = cell_value;
      pin_oe_next = gts_active ? 16'h0000 : cell_oe;
      // low half: value before the buffer, high half: pin after it
      fb_next = {pin_in, cell_value};
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rdata_reg <= PLB_WORD_RESET;
         pin_out_reg <= 16'h0000;
         pin_oe_reg <= 16'h0000;
         fb_reg <= 32'h0000_0000;
      end else begin
         rdata_reg <= rdata_next;
         pin_out_reg <= pin_out_next;
         pin_oe_reg <= pin_oe_next;
         fb_reg <= fb_next;
      end
   end

   assign reg_rdata = rdata_reg;
   assign pin_out = pin_out_reg;
   assign pin_oe = pin_oe_reg;
   assign feedback_to_interconnect = fb_reg;

endmodule

// ### hw/plb_pkg.sv
// Purpose: constants and types for the programmable logic block
// Assumes: one clock, config written over the plain register port
// Notes: word addresses, 36-bit data words, all config resets to zero
package plb_pkg;

   localparam int PLB_INPUTS = 36;
   localparam int PLB_CELLS = 16;
   localparam int PLB_FEEDBACK = 32;
   localparam int PLB_PAL_PER_CELL = 5;
   localparam int PLB_PAL_TERMS = 80;
   localparam int PLB_PLA_TERMS = 32;
   localparam int PLB_CTRL_TERMS = 6;
   localparam int PLB_DATA_W = 36;
   localparam int PLB_ADDR_W = 10;

   // each term is two words: true-literal mask, then complement mask
   localparam logic [9:0] PLB_PAL_BASE = 10'h000;
   localparam logic [9:0] PLB_PAL_END = 10'h0a0;
   localparam logic [9:0] PLB_PLA_BASE = 10'h100;
   localparam logic [9:0] PLB_PLA_END = 10'h140;
   localparam logic [9:0] PLB_CT_BASE = 10'h180;
   localparam logic [9:0] PLB_CT_END = 10'h18c;
   localparam logic [9:0] PLB_OR_BASE = 10'h1c0;
   localparam logic [9:0] PLB_OR_END = 10'h1d0;
   localparam logic [9:0] PLB_CELL_BASE = 10'h200;
   localparam logic [9:0] PLB_CELL_END = 10'h210;
   localparam logic [9:0] PLB_GLOBAL_ADDR = 10'h210;
   localparam logic [9:0] PLB_STATE_ADDR = 10'h220;
   localparam logic [9:0] PLB_FB_ADDR = 10'h221;

   // cell config word fields
   localparam int PLB_MODE_LSB = 0;
   localparam int PLB_CSEL_LSB = 2;
   localparam int PLB_POL_BIT = 4;
   localparam int PLB_PREN_BIT = 5;
   localparam int PLB_OESEL_LSB = 6;

   // global config word fields
   localparam int PLB_CTSUM_LSB = 0;
   localparam int PLB_DUAL_INT_BIT = 6;
   localparam int PLB_DUAL_CELL_LSB = 7;
   localparam int PLB_GTS_EN_BIT = 11;

   localparam logic [35:0] PLB_WORD_RESET = 36'h0_0000_0000;

   typedef enum logic [1:0] {
      PLB_MODE_COMB = 2'b00,
      PLB_MODE_D = 2'b01,
      PLB_MODE_T = 2'b10
   } plb_mode_t;

   typedef enum logic [1:0] {
      PLB_CLK_SYNC = 2'b00,
      PLB_CLK_DUAL = 2'b01,
      PLB_CLK_CT_A = 2'b10,
      PLB_CLK_CT_B = 2'b11
   } plb_clk_sel_t;

   typedef enum logic [2:0] {
      PLB_OE_OFF = 3'b000,
      PLB_OE_ON = 3'b001,
      PLB_OE_CT2 = 3'b010,
      PLB_OE_CT3 = 3'b011,
      PLB_OE_CT4 = 3'b100,
      PLB_OE_CT5 = 3'b101
   } plb_oe_sel_t;

endpackage

// ### hw/plb_macrocell.sv
// Purpose: one macrocell register with clock-edge detection
// Assumes: clock source levels are synchronous samples on clk
// Notes: preset and clear act in the cycle they are seen, no edge needed
`timescale 1ns/10ps
module plb_macrocell
   import plb_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic logic_in,
   input wire logic clk_level,
   input wire logic clk_falling,
   input wire logic [1:0] mode,
   input wire logic preset,
   input wire logic clear,
   output logic state,
   output logic value
);

   logic state_reg;
   logic state_next;
   logic prev_reg;
   logic prev_next;
   logic edge_seen;

   always_comb begin
      prev_next = clk_level;
      edge_seen = clk_falling ? (prev_reg & ~clk_level) : (~prev_reg & clk_level);
      state_next = state_reg;
      if (edge_seen) begin
         unique case (mode)
            PLB_MODE_D: state_next = logic_in;
            PLB_MODE_T: state_next = state_reg ^ logic_in;
            default: state_next = state_reg;
         endcase
      end
      // clear dominates preset when both are asserted
      if (preset) begin
         state_next = 1'b1;
      end
      if (clear) begin
         state_next = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_reg <= 1'b0;
         prev_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         prev_reg <= prev_next;
      end
   end

   assign state = state_reg;
   // combinational cells bypass the register
   assign value = (mode == PLB_MODE_D || mode == PLB_MODE_T) ? state_reg : logic_in;

endmodule

// ### verif/plb_logic_block_properties.sv
// Purpose: port-level checks for the programmable logic block
// Assumes: output-enable config is tracked from register writes seen at the ports
// Notes: bound to plb_logic_block after the module
`timescale 1ns/10ps
module plb_logic_block_properties
   import plb_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [35:0] global_interconnect_array,
   input wire logic [31:0] feedback_to_interconnect,
   input wire logic global_sync_clock,
   input wire logic global_dual_clock,
   input wire logic global_tristate_pin_n,
   input wire logic [15:0] pin_in,
   input wire logic [15:0] pin_out,
   input wire logic [15:0] pin_oe,
   input wire logic [9:0] reg_addr,
   input wire logic [35:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   input wire logic [35:0] reg_rdata
);
   logic [15:0] on_reg, on_next, off_reg, off_next;
   logic gts_reg, gts_next;
   logic force_off;
   assign force_off = gts_reg && !global_tristate_pin_n;
   always_comb begin
      on_next = on_reg;
      off_next = off_reg;
      gts_next = gts_reg;
      if (reg_write && reg_addr >= PLB_CELL_BASE && reg_addr < PLB_CELL_END) begin
         on_next[reg_addr[3:0]] = reg_wdata[8:6] == 3'h1;
         off_next[reg_addr[3:0]] = reg_wdata[8:6] == 3'h0 || reg_wdata[8:6] > 3'h5;
      end
      if (reg_write && reg_addr == PLB_GLOBAL_ADDR) begin
         gts_next = reg_wdata[PLB_GTS_EN_BIT];
      end
   end
   // reset mirrors the design: every buffer off, tristate feature disabled
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         on_reg <= 16'h0000;
         off_reg <= 16'hffff;
         gts_reg <= 1'h0;
      end else begin
         on_reg <= on_next;
         off_reg <= off_next;
         gts_reg <= gts_next;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   property p_rdata_idle;
      !reg_read |=> reg_rdata == 36'h0_0000_0000;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero outside read slot");
   property p_fb_read;
      reg_read && reg_addr == PLB_FB_ADDR |=> reg_rdata == {4'h0, $past(feedback_to_interconnect)};
   endproperty
   a_fb_read: assert property (p_fb_read) else $error("feedback readback differs");
   property p_fb_pins;
      $past(reset_n) |-> feedback_to_interconnect[31:16] == $past(pin_in);
   endproperty
   a_fb_pins: assert property (p_fb_pins) else $error("pin feedback differs from pin level");
   property p_fb_cells;
      feedback_to_interconnect[15:0] == pin_out;
   endproperty
   a_fb_cells: assert property (p_fb_cells) else $error("cell feedback differs from pin drive");
   property p_gts;
      force_off |=> pin_oe == 16'h0000;
   endproperty
   a_gts: assert property (p_gts) else $error("output enabled under global tristate");
   property p_oe_off;
      $past(reset_n) |-> (pin_oe & $past(off_reg)) == 16'h0000;
   endproperty
   a_oe_off: assert property (p_oe_off) else $error("disabled buffer drives");
   property p_oe_on;
      on_reg != 16'h0000 && !force_off |=> (pin_oe & $past(on_reg)) == $past(on_reg);
   endproperty
   a_oe_on: assert property (p_oe_on) else $error("always-on buffer not driving");
   property p_reset_zero;
      $rose(reset_n) |-> pin_out == 16'h0000 && pin_oe == 16'h0000 && feedback_to_interconnect[15:0] == 16'h0000;
   endproperty
   a_reset_zero: assert property (p_reset_zero) else $error("cells not zero after reset");
endmodule

bind plb_logic_block plb_logic_block_properties plb_logic_block_properties_inst (.clk(clk), .reset_n(reset_n),
   .global_interconnect_array(global_interconnect_array), .feedback_to_interconnect(feedback_to_interconnect),
   .global_sync_clock(global_sync_clock), .global_dual_clock(global_dual_clock),
   .global_tristate_pin_n(global_tristate_pin_n), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
   .reg_rdata(reg_rdata));

// ### verif/plb_board_model.sv
// Purpose: board around the logic block: pin resolution and the sync clock source
// Assumes: step pulses come from the bench, one clk cycle each
// Notes: sync clock stands still unless stepped
`timescale 1ns/10ps
module plb_board_model
   import plb_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [15:0] pin_out,
   input wire logic [15:0] pin_oe,
   input wire logic [15:0] drv_val,
   input wire logic [15:0] drv_en,
   input wire logic step,
   output logic [15:0] pin_in,
   output logic global_sync_clock
);
   logic sync_next;
   // undriven pins sit at the pull-up level, never at a stale value
   always_comb begin
      for (int i = 0; i < PLB_CELLS; i++) begin
         pin_in[i] = pin_oe[i] ? pin_out[i] : (drv_en[i] ? drv_val[i] : 1'h1);
      end
   end
   always_comb begin
      sync_next = step ? !global_sync_clock : global_sync_clock;
   end
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         global_sync_clock <= 1'h0;
      end else begin
         global_sync_clock <= sync_next;
      end
   end
endmodule

// ### verif/testbench.sv
// Purpose: directed tests of the logic block through its register port and pins
// Assumes: board model supplies sync clock and pin levels
// Notes: state read at the cell-state address after stimuli that reach cell registers; one unmapped-address read, the rest checked at pins and feedback
`timescale 1ns/10ps
module testbench
   import plb_pkg::*;
;
   logic clk, reset_n, gts_n, dual, step, reg_write, reg_read, sync_clk;
   logic [35:0] gia, reg_wdata, reg_rdata, rv;
   logic [9:0] reg_addr;
   logic [31:0] fb;
   logic [15:0] pin_in, pin_out, pin_oe, drv_val, drv_en;
   logic [8:0] cfg_tab [12] = '{9'h041, 9'h042, 9'h011, 9'h005, 9'h040, 9'h040, 9'h021, 9'h001, 9'h009,
      9'h080, 9'h0c0, 9'h000};
   int d_cells [5] = '{0, 1, 2, 3, 8};
   int n_errors, cmp_count;
   plb_logic_block plb_logic_block_inst (.clk(clk), .reset_n(reset_n), .global_interconnect_array(gia),
      .feedback_to_interconnect(fb), .global_sync_clock(sync_clk), .global_dual_clock(dual),
      .global_tristate_pin_n(gts_n), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata));
   plb_board_model plb_board_model_inst (.clk(clk), .reset_n(reset_n), .pin_out(pin_out), .pin_oe(pin_oe),
      .drv_val(drv_val), .drv_en(drv_en), .step(step), .pin_in(pin_in), .global_sync_clock(sync_clk));
   initial begin
      clk = 1'h0;
      forever #4 clk = ~clk;
   end
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic wr(input logic [9:0] a, input logic [35:0] d);
      @(posedge clk);
      reg_write <= 1'h1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_write <= 1'h0;
   endtask
   task automatic rd(input logic [9:0] a);
      @(posedge clk);
      reg_read <= 1'h1;
      reg_addr <= a;
      @(posedge clk);
      reg_read <= 1'h0;
      #1 rv = reg_rdata;
   endtask
   task automatic chk(input string what, input logic [35:0] exp, input logic [35:0] got);
      cmp_count++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic st(input logic [15:0] m, input logic [15:0] e);
      rd(PLB_STATE_ADDR);
      chk("cell states", 36'(e), rv & 36'(m));
   endtask
   task automatic sclk();
      @(posedge clk);
      step <= 1'h1;
      @(posedge clk);
      step <= 1'h0;
      cyc(4);
   endtask
   // inputs settle through terms, cell and pin stage before anything is looked at
   task automatic drive(input logic [35:0] g);
      @(posedge clk);
      gia <= g;
      cyc(4);
   endtask
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   initial begin
      repeat (3000) @(posedge clk);
      n_errors++;
      summarize();
   end
   initial begin
      reset_n = 1'h0;
      gts_n = 1'h1;
      dual = 1'h0;
      step = 1'h0;
      gia = '0;
      reg_write = 1'h0;
      reg_read = 1'h0;
      reg_addr = '0;
      reg_wdata = '0;
      drv_val = '0;
      drv_en = '0;
      n_errors = 0;
      cmp_count = 0;
      cyc(16);
      reset_n <= 1'h1;
      st(16'hffff, 16'h0000);
      rd(10'h3ff);
      chk("unmapped read", '0, rv);
      for (int i = 0; i < 12; i++) wr(PLB_CELL_BASE + 10'(i), 36'(cfg_tab[i]));
      foreach (d_cells[i]) wr(10'(10 * d_cells[i]), 36'h1);
      wr(PLB_PLA_BASE, 36'h2);
      wr(PLB_OR_BASE + 10'h4, 36'h1);
      wr(PLB_OR_BASE + 10'h5, 36'h1);
      wr(PLB_CT_BASE, 36'h4);
      wr(PLB_CT_BASE + 10'h2, 36'h8);
      wr(PLB_CT_BASE + 10'h4, 36'h30);
      wr(PLB_CT_BASE + 10'h6, 36'h30);
      wr(PLB_GLOBAL_ADDR, 36'h4);
      drive(36'h1);
      sclk();
      st(16'h0007, 16'h0003);
      chk("cell 0/1 pins", 36'hf, 36'({pin_oe[1:0], pin_out[1:0]}));
      chk("feedback 0/1", 36'h3_0003, 36'(fb & 32'h0003_0003));
      sclk();
      st(16'h0007, 16'h0007);
      sclk();
      st(16'h0007, 16'h0005);
      drive(36'h0);
      sclk();
      sclk();
      st(16'h0007, 16'h0000);
      drive(36'h1);
      @(posedge clk) dual <= 1'h1;
      cyc(4);
      st(16'h0008, 16'h0008);
      drive(36'h11);
      st(16'h0100, 16'h0100);
      chk("ct enables", 36'h1, 36'(pin_oe[10:9]));
      drive(36'h31);
      chk("ct enables", 36'h3, 36'(pin_oe[10:9]));
      drive(36'h4);
      st(16'h00c0, 16'h0040);
      drive(36'h8);
      st(16'h00c0, 16'h0000);
      drive(36'h2);
      chk("shared term pins", 36'h3, 36'(pin_out[5:4]));
      drive(36'h0);
      chk("shared term pins", 36'h0, 36'(pin_out[5:4]));
      @(posedge clk) drv_en <= 16'h0800;
      drv_val <= 16'h0000;
      cyc(4);
      chk("input pin", 36'h0, 36'({fb[27], pin_oe[11]}));
      @(posedge clk) drv_val <= 16'h0800;
      cyc(4);
      chk("input pin", 36'h2, 36'({fb[27], pin_oe[11]}));
      rd(PLB_FB_ADDR);
      chk("feedback read", 36'h1800_0000, rv & 36'h1801_0000);
      @(posedge clk) gts_n <= 1'h0;
      cyc(4);
      chk("oe, tristate off", 36'h1, 36'(pin_oe[0]));
      wr(PLB_GLOBAL_ADDR, 36'h804);
      cyc(3);
      chk("oe under tristate", '0, 36'(pin_oe));
      @(posedge clk) gts_n <= 1'h1;
      cyc(4);
      chk("oe after tristate", 36'h1, 36'(pin_oe[0]));
      // dual clock from cell 4 equation (pool term on input 1); cell 3 captures input 0
      wr(PLB_GLOBAL_ADDR, 36'ha44);
      drive(36'h2);
      st(16'h0008, 16'h0000);
      summarize();
   end
endmodule
